// >>> logic/bbl_host_ctrl.sv
// Host controller that resets the flash disk, waits for its download and runs byte-wide cycles
//
// Functional notes
// - The host holds the device reset input low from its own reset and then releases it.
// - Without a busy pin the host waits a fixed delay covering the whole download before any access.
// - The host makes no access before the download has completed or its download wait has run out.
// - Strobes drive the device clock, so each strobe edge is made exactly once and cleanly.
`timescale 1ns/1ps
`default_nettype none
module bbl_host_ctrl
  import bbl_pkg::*;
#(
  parameter int unsigned DOWNLOAD_WAIT = DOWNLOAD_CYCLES
)
(
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Configuration
  input  wire logic                busy_pin_present,
  input  wire logic [1:0]          cascade_position,
  // Host request port
  input  wire logic                req_valid,
  input  wire bbl_pkg::host_req_s  req,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [7:0]               rsp_rdata,
  output logic                     device_ready,
  output logic                     download_timeout,
  // Device pins
  output logic                     host_reset_in_n,
  input  wire logic                busy_n,
  output bbl_pkg::mem_pins_s       pins,
  input  wire logic [7:0]          read_data
);

  import bbl_pkg::*;

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  ctl_state_e  state_r;
  ctl_state_e  state_nxt;
  mem_pins_s   pins_r;
  mem_pins_s   pins_nxt;
  host_req_s   cur_r;
  logic        rst_out_r;
  logic        ready_r;
  logic        timeout_r;
  logic        rsp_valid_r;
  logic [7:0]  rdata_r;

  logic        tmr_load;
  logic [15:0] tmr_value;
  logic        tmr_expired;

  bbl_timer u_timer (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .load       (tmr_load),
    .load_value (tmr_value),
    .expired    (tmr_expired)
  );

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire busy_done   = busy_pin_present ? busy_n : 1'b0;
  wire wait_over   = busy_done || tmr_expired;
  wire take_req    = (state_r == ST_IDLE) && req_valid;
  wire strobe_done = (state_r == ST_STROBE) && tmr_expired;
  wire recov_done  = (state_r == ST_RECOVER) && tmr_expired;
  wire [12:0] idle_addr = {cascade_position, 11'h000};

  assign req_ready        = (state_r == ST_IDLE);
  assign rsp_valid        = rsp_valid_r;
  assign rsp_rdata        = rdata_r;
  assign device_ready     = ready_r;
  assign download_timeout = timeout_r;
  assign host_reset_in_n  = rst_out_r;
  assign pins             = pins_r;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    tmr_load  = 1'b0;
    tmr_value = 16'h0000;
    pins_nxt  = pins_r;
    unique case (state_r)
      ST_RESET:
      begin
        if (tmr_expired)
        begin
          state_nxt = ST_WAIT_BUSY;
          tmr_load  = 1'b1;
          tmr_value = 16'(DOWNLOAD_WAIT);
        end
      end
      ST_WAIT_BUSY:
      begin
        if (wait_over)
        begin
          // Park the address on this chip's window base
          state_nxt     = ST_IDLE;
          pins_nxt.addr = idle_addr;
        end
      end
      ST_IDLE:
      begin
        if (take_req)
        begin
          state_nxt          = ST_STROBE;
          tmr_load           = 1'b1;
          tmr_value          = 16'(STROBE_CYCLES);
          pins_nxt.ce_n      = 1'b0;
          pins_nxt.oe_n      = req.write;
          pins_nxt.we_n      = !req.write;
          pins_nxt.addr      = req.addr;
          pins_nxt.dout      = req.wdata;
          pins_nxt.dout_oe_n = !req.write;
        end
      end
      ST_STROBE:
      begin
        if (tmr_expired)
        begin
          state_nxt     = ST_RECOVER;
          tmr_load      = 1'b1;
          tmr_value     = 16'(RECOVER_CYCLES);
          pins_nxt.ce_n = 1'b1;
          pins_nxt.oe_n = 1'b1;
          pins_nxt.we_n = 1'b1;
        end
      end
      ST_RECOVER:
      begin
        if (tmr_expired)
        begin
          state_nxt          = ST_IDLE;
          pins_nxt.dout_oe_n = 1'b1;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r     <= ST_RESET;
      pins_r      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 13'h0000, dout: 8'h00, dout_oe_n: 1'b1};
      cur_r       <= '0;
      rst_out_r   <= 1'b0;
      ready_r     <= 1'b0;
      timeout_r   <= 1'b0;
      rsp_valid_r <= 1'b0;
      rdata_r     <= 8'h00;
    end
    else
    begin
      state_r     <= state_nxt;
      pins_r      <= pins_nxt;
      rst_out_r   <= (state_nxt != ST_RESET);
      ready_r     <= (state_nxt != ST_RESET) && (state_nxt != ST_WAIT_BUSY);
      rsp_valid_r <= strobe_done && !cur_r.write;
      if ((state_r == ST_WAIT_BUSY) && !busy_done && tmr_expired)
        timeout_r <= 1'b1;
      if (take_req)
        cur_r <= req;
      if (strobe_done && !cur_r.write)
        rdata_r <= read_data;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence s_strobe_start;
    $fell(pins.ce_n);
  endsequence

  chk_no_early_access: assert property (@(posedge core_clk) disable iff (!arst_n)
    !ready_r |-> pins.ce_n)
    else $error("device strobed before download done");
  chk_reset_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(host_reset_in_n) |-> $past(state_r) == ST_RESET)
    else $error("reset released out of sequence");
  chk_single_edge: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_strobe_start |=> !pins.ce_n [*4] ##1 pins.ce_n)
    else $error("strobe width wrong");
  chk_oe_we_excl: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(pins.oe_n == 1'b0 && pins.we_n == 1'b0))
    else $error("read and write strobes together");
  chk_drive_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pins.we_n |-> !pins.dout_oe_n)
    else $error("write without data drive");
  chk_read_rsp: assert property (@(posedge core_clk) disable iff (!arst_n)
    (s_strobe_start and !pins.oe_n) |-> ##5 rsp_valid)
    else $error("read answer missing");
  chk_busy_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
    (state_r == ST_WAIT_BUSY && busy_pin_present && busy_n) |=> ready_r)
    else $error("busy release not followed");
  chk_timeout_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(timeout_r) |-> ready_r)
    else $error("timeout did not free host");

endmodule
`default_nettype wire

// >>> logic/bbl_pkg.sv
// Package: pin bundles, timing constants and states for the boot block loader host controller
`default_nettype none
package bbl_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned RESET_WIDTH_NS     = 22;
  localparam int unsigned RESET_CYCLES       = (RESET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DOWNLOAD_MAX_US    = 1000;
  localparam int unsigned DOWNLOAD_CYCLES    = (DOWNLOAD_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_WIDTH_NS    = 130;
  localparam int unsigned STROBE_CYCLES      = (STROBE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_NS         = 11;
  localparam int unsigned RECOVER_CYCLES     = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Window geometry
  localparam int unsigned ADDR_W             = 13;
  localparam int unsigned BOOT_BYTES         = 512;
  localparam int unsigned BOOT_ALIAS_STRIDE  = 13'h200;
  localparam logic [12:0] HIGH_BOOT_BASE     = 13'h1800;

  // Memory-side pin group toward the device
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [12:0] addr;
    logic [7:0]  dout;
    logic        dout_oe_n;
  } mem_pins_s;

  // Host-side request
  typedef struct packed {
    logic        write;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } host_req_s;

  typedef enum logic [2:0] {
    ST_RESET,
    ST_WAIT_BUSY,
    ST_IDLE,
    ST_STROBE,
    ST_RECOVER
  } ctl_state_e;

endpackage
`default_nettype wire

// >>> logic/bbl_timer.sv
// Down counter used for download timeout, strobe width and recovery time
`timescale 1ns/1ps
`default_nettype none
module bbl_timer
  import bbl_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  // Control
  input  wire logic        load,
  input  wire logic [15:0] load_value,
  // Status
  output logic             expired
);

  logic [15:0] count_r;
  logic [15:0] count_nxt;

  assign count_nxt = load ? load_value : ((count_r != 16'h0000) ? count_r - 16'h0001 : count_r);
  // Status comes from the register alone, so callers may load on it without a loop
  assign expired   = (count_r == 16'h0000);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      count_r <= 16'h0000;
    else
      count_r <= count_nxt;
  end

endmodule
`default_nettype wire

// >>> verif/bbl_dev_model.sv
// Behavioural flash disk device seen from its host pins
`timescale 1ns/1ps
`default_nettype none
module bbl_dev_model
  import bbl_pkg::*;
#(
  parameter int DL = 20
)
(
  // Control
  input  wire logic         clk,
  input  wire logic         rst_in_n,
  input  wire logic [2:0]   fault,
  // Pins
  input  wire bbl_pkg::mem_pins_s pins,
  output logic              busy_low,
  output logic [7:0]        dq,
  output int                wr_cnt,
  output logic [7:0]        wr_last
);
  logic [7:0]  boot [512];
  logic [7:0]  last = 8'h00;
  logic        por_n = 1'b0;
  logic [47:0] wr_code = '0;
  logic [47:0] rd_code = '0;
  int          cnt;
  wire         dev_rst_n = rst_in_n && por_n;
  wire        rd   = !pins.ce_n && !pins.oe_n;
  wire        hit  = pins.addr < 13'h0800 || pins.addr >= 13'h1800;
  wire        done = !fault[2] && cnt == (fault[1:0] != 2'h0 ? 2 * DL : DL);
  // Released bus shows the inverse of its last value
  assign dq = rd ? (hit ? boot[pins.addr[8:0]] : 8'h00) : ~last;
  // Power-on one-shot of the variant without a reset pin
  initial #100 por_n = 1'b1;
  always @(posedge clk or negedge dev_rst_n)
    if (!dev_rst_n)
    begin
      busy_low <= 1'b1;
      cnt <= 0;
    end
    else if (busy_low)
    begin
      cnt <= cnt + 1;
      if (done)
      begin
        busy_low <= 1'b0;
        for (int i = 0; i < 512; i++)
          boot[i] <= fault[1] ? 8'hff : i[7:0] ^ 8'h3c;
      end
    end
  // Six-byte running stand-in codes over bytes read and written
  always @(posedge clk)
    if (rd)
    begin
      last <= dq;
      rd_code <= {rd_code[39:0], rd_code[47:40] ^ dq};
    end
  initial wr_cnt = 0;
  // Each write strobe counts once; data latches on its closing edge
  always @(negedge pins.we_n)
    if (!pins.ce_n && !pins.dout_oe_n)
      wr_cnt <= wr_cnt + 1;
  always @(posedge pins.we_n)
    if (!pins.dout_oe_n)
    begin
      wr_last <= pins.dout;
      wr_code <= {wr_code[39:0], wr_code[47:40] ^ pins.dout};
    end
endmodule
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the boot block loader host controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bbl_pkg::*;
  localparam int DLW = 50;
  localparam int DL = 20;
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       busy_pin_present = 1'b1;
  logic       req_valid = 1'b0;
  host_req_s  req = '0;
  logic [2:0] fault = 3'h0;
  logic [1:0] cascade_position = 2'h0;
  logic       req_ready, rsp_valid, device_ready, download_timeout, host_reset_in_n, busy_low;
  logic [7:0] rsp_rdata, dq, wr_last;
  mem_pins_s  pins;
  int         wr_cnt;
  int         n_fail = 0;
  int         checks_done = 0;
  wire        busy_n = busy_low ? 1'b0 : 1'b1;
  wire [7:0]  bus = pins.dout_oe_n ? dq : pins.dout;

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  bbl_host_ctrl #(.DOWNLOAD_WAIT(DLW)) uut (.core_clk(core_clk), .arst_n(arst_n),
    .busy_pin_present(busy_pin_present), .cascade_position(cascade_position), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .device_ready(device_ready),
    .download_timeout(download_timeout), .host_reset_in_n(host_reset_in_n), .busy_n(busy_n),
    .pins(pins), .read_data(bus));
  bbl_dev_model #(.DL(DL)) dev (.clk(core_clk), .rst_in_n(host_reset_in_n), .fault(fault), .pins(pins),
    .busy_low(busy_low), .dq(dq), .wr_cnt(wr_cnt), .wr_last(wr_last));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic give_up(input string what);
    check(what, 32'h0, 32'h1);
    summarize();
  endtask

  // Reset both ends, then count cycles until the host reports ready
  task automatic boot(input logic [2:0] f, input logic bp, output int n);
    fault = f;
    busy_pin_present = bp;
    arst_n = 1'b0;
    repeat (6) @(negedge core_clk);
    check("reset_out", host_reset_in_n, 1'b0);
    check("busy_n", busy_n, 1'b0);
    check("ready", {device_ready, req_ready}, 2'b00);
    arst_n = 1'b1;
    n = 0;
    while (device_ready !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 200)
        give_up("device_ready");
    end
  endtask

  task automatic access(input logic w, input logic [12:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    while (req_ready !== 1'b1)
    begin
      @(negedge core_clk);
      if (++n > 50)
        give_up("req_ready");
    end
    req_valid = 1'b1;
    req = '{write: w, addr: a, wdata: d};
    @(negedge core_clk);
    req_valid = 1'b0;
    n = 0;
    while (!w && rsp_valid !== 1'b1)
    begin
      @(negedge core_clk);
      if (++n > 50)
        give_up("rsp_valid");
    end
    q = rsp_rdata;
  endtask

  task automatic t_alias;
    int n;
    logic [7:0] q;
    logic [8:0] o;
    boot(3'h0, 1'b1, n);
    check("busy_n", busy_n, 1'b1);
    check("in_time", n >= DL && n < DLW, 1'b1);
    check("timeout", download_timeout, 1'b0);
    for (int b = 0; b < 8; b++)
    begin
      o = 9'(b * 71 + 3);
      access(1'b0, (b < 4 ? 13'h0000 : 13'h1000) + 13'(b * 512) + 13'(o), 8'h00, q);
      check("boot_byte", q, o[7:0] ^ 8'h3c);
    end
    $display("done alias");
  endtask

  task automatic t_write;
    int n, w0;
    logic [7:0] q;
    boot(3'h0, 1'b1, n);
    w0 = wr_cnt;
    access(1'b1, 13'h0800, 8'ha5, q);
    access(1'b1, 13'h0801, 8'h5a, q);
    access(1'b1, 13'h1000, 8'hc3, q);
    access(1'b0, 13'h01ff, 8'h00, q);
    check("rd_after_wr", q, 8'hc3);
    check("wr_edges", wr_cnt - w0, 3);
    check("wr_data", wr_last, 8'hc3);
    $display("done write");
  endtask

  task automatic t_fallback;
    int n;
    logic [7:0] q;
    for (int f = 1; f < 3; f++)
    begin
      boot(3'(f), 1'b1, n);
      check("fb_time", n >= 2 * DL, 1'b1);
      check("fb_busy", busy_n, 1'b1);
      check("fb_tmo", download_timeout, 1'b0);
    end
    boot(3'h1, 1'b1, n);
    access(1'b0, 13'h1923, 8'h00, q);
    check("fb_byte", q, 8'h23 ^ 8'h3c);
    $display("done fallback");
  endtask

  task automatic t_stall;
    int n;
    logic [7:0] q;
    boot(3'h4, 1'b1, n);
    check("stuck_tmo", download_timeout, 1'b1);
    check("stuck_wait", n >= DLW, 1'b1);
    cascade_position = 2'h2;
    boot(3'h0, 1'b0, n);
    check("nobusy_wait", n >= DLW, 1'b1);
    check("park_addr", pins.addr, 13'h1000);
    access(1'b0, 13'h0004, 8'h00, q);
    check("nobusy_byte", q, 8'h04 ^ 8'h3c);
    $display("done stall");
  endtask

  initial
  begin
    @(negedge core_clk);
    t_alias();
    t_write();
    t_fallback();
    t_stall();
    summarize();
  end
endmodule
`default_nettype wire
